// file: pmw_pkg.sv
/*
 pmw_pkg: constants for the power-management and wake-on-LAN block.
 assumes a 16-bit host register port with word offsets as printed.
*/
package pmw_pkg;
  localparam int unsigned REG_AW = 8;
  localparam int unsigned REG_DW = 16;
  localparam logic [7:0] OFF_GLOBAL_RESET_WAKE = 8'h26;
  localparam logic [7:0] OFF_WAKE_FRAME_CONTROL = 8'h2a;
  localparam logic [7:0] OFF_WAKE_FRAME0 = 8'h30;
  localparam logic [7:0] OFF_WAKE_FRAME1 = 8'h40;
  localparam logic [7:0] OFF_WAKE_FRAME2 = 8'h50;
  localparam logic [7:0] OFF_WAKE_FRAME3 = 8'h60;
  localparam logic [7:0] OFF_INTERRUPT_ENABLE = 8'h90;
  localparam logic [7:0] OFF_INTERRUPT_STATUS = 8'h92;
  localparam logic [7:0] OFF_WAKE_UP_TIME = 8'ha6;
  localparam logic [7:0] OFF_POWER_MODE_CONTROL = 8'hd4;
  localparam logic [7:0] OFF_PHY_SPECIAL_CONTROL = 8'hf4;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_ENERGY = 2'h1;
  localparam logic [1:0] MODE_SOFT_DOWN = 2'h2;
  localparam logic [1:0] MODE_SAVING = 2'h3;
  localparam int unsigned ISR_ENERGY = 2;
  localparam int unsigned ISR_LINKUP = 3;
  localparam int unsigned ISR_REMOTE = 4;
  localparam int unsigned ISR_FRAME = 5;
  localparam int unsigned PMC_PME_ENERGY = 8;
  localparam int unsigned PMC_PME_LINKUP = 9;
  localparam int unsigned PMC_PME_REMOTE = 10;
  localparam int unsigned PMC_PME_FRAME = 11;
  localparam int unsigned PHY_SAVE_BIT = 10;
  localparam int unsigned WFC_REMOTE_EN = 7;
  localparam int unsigned SYNC_BYTES = 6;
  localparam int unsigned ADDR_BYTES = 6;
  localparam int unsigned ADDR_COPIES = 16;
  localparam logic [7:0] SYNC_VALUE = 8'hff;
  localparam logic [15:0] RESET_ZERO = 16'h0000;
  localparam logic [15:0] WAKE_TIME_RESET = 16'h0010;
  localparam int unsigned CLOCK_HZ = 10000000;
  localparam int unsigned WAKE_TICK_US = 1;
  localparam int unsigned WAKE_TICK_CYCLES = (CLOCK_HZ / 1000000) * WAKE_TICK_US;
endpackage

// file: pmw_remote_scan.sv
/*
 pmw_remote_scan: scans received bytes for the remote wake sequence.
 assumes one byte per valid cycle and a frame start strobe from the mac; no end strobe is used.
*/
`timescale 1ns/1ps
module pmw_remote_scan #(
  parameter int unsigned COPIES = pmw_pkg::ADDR_COPIES
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic scan_en_in,
  input wire logic start_in,
  input wire logic byte_valid_in,
  input wire logic [7:0] byte_in,
  input wire logic [47:0] station_addr_in,
  output logic found_out
);
  initial begin
    if (COPIES < 1 || COPIES > 255) $error("copies out of range");
  end
  typedef enum logic [1:0] {SC_SYNC, SC_ADDR, SC_DONE} pmw_scan_type;
  pmw_scan_type st_q;
  logic [2:0] sync_cnt_q;
  logic [2:0] byte_idx_q;
  logic [7:0] copy_cnt_q;
  logic [7:0] expect_byte;
  always_comb begin
    expect_byte = station_addr_in[47 - 8 * byte_idx_q -: 8];
  end
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      st_q <= SC_SYNC;
      sync_cnt_q <= 3'h0;
      byte_idx_q <= 3'h0;
      copy_cnt_q <= 8'h00;
    end else if (clk_en_in) begin
      if (start_in || !scan_en_in) begin
        st_q <= SC_SYNC;
        sync_cnt_q <= 3'h0;
        byte_idx_q <= 3'h0;
        copy_cnt_q <= 8'h00;
      end else if (byte_valid_in) begin
        case (st_q)
          SC_SYNC: begin
            if (byte_in == pmw_pkg::SYNC_VALUE) begin
              if (sync_cnt_q >= 3'(pmw_pkg::SYNC_BYTES - 1)) begin
                st_q <= SC_ADDR;
              end else begin
                sync_cnt_q <= sync_cnt_q + 3'h1;
              end
            end else begin
              sync_cnt_q <= 3'h0;
            end
          end
          SC_ADDR: begin
            if (byte_in == expect_byte) begin
              if (byte_idx_q == 3'(pmw_pkg::ADDR_BYTES - 1)) begin
                byte_idx_q <= 3'h0;
                if (copy_cnt_q == 8'(COPIES - 1)) begin
                  st_q <= SC_DONE;
                end else begin
                  copy_cnt_q <= copy_cnt_q + 8'h01;
                end
              end else begin
                byte_idx_q <= byte_idx_q + 3'h1;
              end
            end else if (byte_idx_q == 3'h0 && copy_cnt_q == 8'h00
                         && byte_in == pmw_pkg::SYNC_VALUE) begin
              st_q <= SC_ADDR; // extra sync bytes before the first copy
            end else begin
              st_q <= SC_SYNC;
              byte_idx_q <= 3'h0;
              copy_cnt_q <= 8'h00;
              sync_cnt_q <= (byte_in == pmw_pkg::SYNC_VALUE) ? 3'h1 : 3'h0;
            end
          end
          SC_DONE: st_q <= SC_DONE;
          default: st_q <= SC_SYNC;
        endcase
      end
    end
  end
  always_comb begin
    found_out = (st_q == SC_DONE);
  end
endmodule

// file: pmw_power_wake.sv
/*
 pmw_power_wake: power modes, chip power-down reset and wake events.
 assumes synchronous inputs, a 16-bit host register port, and a mac that
 delivers received bytes with start/end and a crc/address status at end.
*/
`timescale 1ns/1ps
// Summary of operation
// - writing mode 10 into the power-mode field enters soft power-down
// - soft power-down stops clocks, phy, mac; registers other than status hold; only wake read served
// - a read of the global reset register leaves soft power-down to normal
// - power saving needs autoneg on, cable off, mode 11 and phy bit 10
// - power saving keeps clocks and mac running and registers fully accessible
// - power saving powers down only the receiver; line activity powers it up
// - power-down pin low powers off; rising edge resets all registers
// - wake events can drive the interrupt output, the event output, or both
// - status bit 2 on energy detect, bit 3 on link-up
// - status bit 5 on wake-up frame match, bit 4 on remote wake frame
// - energy event only after energy present longer than the wake-up time
// - four wake-up frame crc patterns, enabled by control bits 0 to 3
// - control bit 7 enables remote wake scanning of frames for this node
// - sequence is six ff bytes then sixteen unbroken station address copies
// - remote wake frame must be valid with good crc and accepted destination
// - broadcast frames count when the repeated addresses match the station
// - frames without the sequence are dropped; found sequence raises event output
// - search ignores the carried protocol, any position in the frame
// - mode field encodes normal, energy, soft down, saving; reset is normal
// - event output for energy needs power-mode control bit 8
module pmw_power_wake #(
  parameter int unsigned TICK_CYCLES = pmw_pkg::WAKE_TICK_CYCLES
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic chip_power_down_pin_in,
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [47:0] station_addr_in,
  input wire logic autoneg_en_in,
  input wire logic cable_connected_in,
  input wire logic line_activity_in,
  input wire logic energy_in,
  input wire logic link_up_in,
  input wire logic rx_start_in,
  input wire logic rx_byte_valid_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_end_in,
  input wire logic rx_good_in,
  input wire logic rx_dest_ok_in,
  input wire logic [15:0] rx_frame_crc_in,
  output logic [15:0] reg_rdata_out,
  output logic clocks_on_out,
  output logic mac_on_out,
  output logic phy_tx_on_out,
  output logic phy_rx_on_out,
  output logic chip_reset_out,
  output logic interrupt_out_n,
  output logic power_event_out
);
  initial begin
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) $error("tick cycles out of range");
  end
  logic [15:0] power_mode_control_q;
  logic [15:0] phy_special_control_q;
  logic [15:0] wake_frame_control_q;
  logic [15:0] interrupt_enable_q;
  logic [15:0] interrupt_status_q;
  logic [15:0] wake_time_q;
  logic [15:0] frame_crc_q [4];
  logic soft_down_q;
  logic pin_q;
  logic por_d;
  logic live;
  logic wr;
  logic rd;
  logic saving_cond;
  logic [15:0] tick_q;
  logic [15:0] energy_cnt_q;
  logic energy_evt;
  logic link_q;
  logic linkup_evt;
  logic remote_found;
  logic remote_evt;
  logic frame_evt;
  logic [15:0] set_bits;
  logic [15:0] rdata_d;
  logic [1:0] mode;

  always_comb begin
    mode = power_mode_control_q[1:0];
    por_d = chip_power_down_pin_in && !pin_q;
    live = clk_en_in && chip_power_down_pin_in && !por_d;
    wr = live && reg_wr_in && !soft_down_q;
    rd = live && reg_rd_in;
    saving_cond = autoneg_en_in && !cable_connected_in && mode == pmw_pkg::MODE_SAVING
                  && phy_special_control_q[pmw_pkg::PHY_SAVE_BIT];
  end

  // power-down pin edge tracking
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pin_q <= 1'b1;
      chip_reset_out <= 1'b0;
    end else if (clk_en_in) begin
      pin_q <= chip_power_down_pin_in;
      chip_reset_out <= por_d;
    end
  end

  // host-written configuration
  always_ff @(posedge mclk_in) begin
    if (reset_in || (clk_en_in && por_d)) begin
      power_mode_control_q <= pmw_pkg::RESET_ZERO;
      phy_special_control_q <= pmw_pkg::RESET_ZERO;
      wake_frame_control_q <= pmw_pkg::RESET_ZERO;
      interrupt_enable_q <= pmw_pkg::RESET_ZERO;
      wake_time_q <= pmw_pkg::WAKE_TIME_RESET;
      for (int i = 0; i < 4; i++) begin
        frame_crc_q[i] <= pmw_pkg::RESET_ZERO;
      end
    end else if (wr) begin
      case (reg_addr_in)
        pmw_pkg::OFF_POWER_MODE_CONTROL: power_mode_control_q <= reg_wdata_in;
        pmw_pkg::OFF_PHY_SPECIAL_CONTROL: phy_special_control_q <= reg_wdata_in;
        pmw_pkg::OFF_WAKE_FRAME_CONTROL: wake_frame_control_q <= reg_wdata_in;
        pmw_pkg::OFF_INTERRUPT_ENABLE: interrupt_enable_q <= reg_wdata_in;
        pmw_pkg::OFF_WAKE_UP_TIME: wake_time_q <= reg_wdata_in;
        pmw_pkg::OFF_WAKE_FRAME0: frame_crc_q[0] <= reg_wdata_in;
        pmw_pkg::OFF_WAKE_FRAME1: frame_crc_q[1] <= reg_wdata_in;
        pmw_pkg::OFF_WAKE_FRAME2: frame_crc_q[2] <= reg_wdata_in;
        pmw_pkg::OFF_WAKE_FRAME3: frame_crc_q[3] <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // soft power-down state
  always_ff @(posedge mclk_in) begin
    if (reset_in || (clk_en_in && por_d)) begin
      soft_down_q <= 1'b0;
    end else if (rd && soft_down_q && reg_addr_in == pmw_pkg::OFF_GLOBAL_RESET_WAKE) begin
      soft_down_q <= 1'b0;
    end else if (wr && reg_addr_in == pmw_pkg::OFF_POWER_MODE_CONTROL
                 && reg_wdata_in[1:0] == pmw_pkg::MODE_SOFT_DOWN) begin
      soft_down_q <= 1'b1;
    end
  end

  // block power controls
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      clocks_on_out <= 1'b1;
      mac_on_out <= 1'b1;
      phy_tx_on_out <= 1'b1;
      phy_rx_on_out <= 1'b1;
    end else if (clk_en_in) begin
      clocks_on_out <= chip_power_down_pin_in && !soft_down_q;
      mac_on_out <= chip_power_down_pin_in && !soft_down_q;
      phy_tx_on_out <= chip_power_down_pin_in && !soft_down_q;
      phy_rx_on_out <= chip_power_down_pin_in && !soft_down_q
                       && !(saving_cond && !line_activity_in);
    end
  end

  // energy qualification timer
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      tick_q <= 16'h0000;
      energy_cnt_q <= 16'h0000;
    end else if (live) begin
      if (!energy_in) begin
        tick_q <= 16'h0000;
        energy_cnt_q <= 16'h0000;
      end else if (tick_q == 16'(TICK_CYCLES - 1)) begin
        tick_q <= 16'h0000;
        if (energy_cnt_q <= wake_time_q) begin
          energy_cnt_q <= energy_cnt_q + 16'h0001;
        end
      end else begin
        tick_q <= tick_q + 16'h0001;
      end
    end
  end

  always_comb begin
    energy_evt = live && energy_in && tick_q == 16'(TICK_CYCLES - 1)
                 && energy_cnt_q == wake_time_q;
    linkup_evt = live && link_up_in && !link_q;
    remote_evt = live && rx_end_in && rx_good_in && rx_dest_ok_in && remote_found
                 && wake_frame_control_q[pmw_pkg::WFC_REMOTE_EN];
    frame_evt = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (wake_frame_control_q[i] && rx_frame_crc_in == frame_crc_q[i]) begin
        frame_evt = live && rx_end_in && rx_good_in && rx_dest_ok_in;
      end
    end
    set_bits = 16'h0000;
    set_bits[pmw_pkg::ISR_ENERGY] = energy_evt;
    set_bits[pmw_pkg::ISR_LINKUP] = linkup_evt;
    set_bits[pmw_pkg::ISR_REMOTE] = remote_evt;
    set_bits[pmw_pkg::ISR_FRAME] = frame_evt;
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      link_q <= 1'b0;
    end else if (live) begin
      link_q <= link_up_in;
    end
  end

  pmw_remote_scan #(
    .COPIES(pmw_pkg::ADDR_COPIES)
  ) u_scan (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .clk_en_in(live),
    .scan_en_in(wake_frame_control_q[pmw_pkg::WFC_REMOTE_EN]),
    .start_in(rx_start_in),
    .byte_valid_in(rx_byte_valid_in),
    .byte_in(rx_byte_in),
    .station_addr_in(station_addr_in),
    .found_out(remote_found)
  );

  // sticky status, write one to clear, set wins
  always_ff @(posedge mclk_in) begin
    if (reset_in || (clk_en_in && por_d)) begin
      interrupt_status_q <= pmw_pkg::RESET_ZERO;
    end else if (live) begin
      if (wr && reg_addr_in == pmw_pkg::OFF_INTERRUPT_STATUS) begin
        interrupt_status_q <= (interrupt_status_q & ~reg_wdata_in) | set_bits;
      end else begin
        interrupt_status_q <= interrupt_status_q | set_bits;
      end
    end
  end

  // wake reporting
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      interrupt_out_n <= 1'b1;
      power_event_out <= 1'b0;
    end else if (clk_en_in) begin
      interrupt_out_n <= !(|(interrupt_status_q & interrupt_enable_q));
      power_event_out <= (interrupt_status_q[pmw_pkg::ISR_ENERGY]
                          && power_mode_control_q[pmw_pkg::PMC_PME_ENERGY])
                       || (interrupt_status_q[pmw_pkg::ISR_LINKUP]
                          && power_mode_control_q[pmw_pkg::PMC_PME_LINKUP])
                       || (interrupt_status_q[pmw_pkg::ISR_REMOTE]
                          && power_mode_control_q[pmw_pkg::PMC_PME_REMOTE])
                       || (interrupt_status_q[pmw_pkg::ISR_FRAME]
                          && power_mode_control_q[pmw_pkg::PMC_PME_FRAME]);
    end
  end

  // read data
  always_comb begin
    rdata_d = 16'h0000;
    case (reg_addr_in)
      pmw_pkg::OFF_POWER_MODE_CONTROL: rdata_d = power_mode_control_q;
      pmw_pkg::OFF_PHY_SPECIAL_CONTROL: rdata_d = phy_special_control_q;
      pmw_pkg::OFF_WAKE_FRAME_CONTROL: rdata_d = wake_frame_control_q;
      pmw_pkg::OFF_INTERRUPT_ENABLE: rdata_d = interrupt_enable_q;
      pmw_pkg::OFF_INTERRUPT_STATUS: rdata_d = interrupt_status_q;
      pmw_pkg::OFF_WAKE_UP_TIME: rdata_d = wake_time_q;
      pmw_pkg::OFF_WAKE_FRAME0: rdata_d = frame_crc_q[0];
      pmw_pkg::OFF_WAKE_FRAME1: rdata_d = frame_crc_q[1];
      pmw_pkg::OFF_WAKE_FRAME2: rdata_d = frame_crc_q[2];
      pmw_pkg::OFF_WAKE_FRAME3: rdata_d = frame_crc_q[3];
      default: rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (rd && !soft_down_q) begin
      reg_rdata_out <= rdata_d;
    end
  end

  a_soft_entry: assert property (@(posedge mclk_in) disable iff (reset_in)
    wr && reg_addr_in == pmw_pkg::OFF_POWER_MODE_CONTROL
    && reg_wdata_in[1:0] == pmw_pkg::MODE_SOFT_DOWN
    |=> soft_down_q ##1 (!clocks_on_out || !$past(clk_en_in)))
    else $error("soft power-down not entered");
  a_soft_hold: assert property (@(posedge mclk_in) disable iff (reset_in)
    soft_down_q && clk_en_in && !por_d |=> $stable(power_mode_control_q))
    else $error("register changed in soft power-down");
  a_soft_exit: assert property (@(posedge mclk_in) disable iff (reset_in)
    rd && soft_down_q && reg_addr_in == pmw_pkg::OFF_GLOBAL_RESET_WAKE
    |=> !soft_down_q ##1 (clocks_on_out || !$past(clk_en_in)))
    else $error("wake read did not leave soft power-down");
  a_rx_saving: assert property (@(posedge mclk_in) disable iff (reset_in)
    clk_en_in && !soft_down_q && chip_power_down_pin_in && saving_cond && !line_activity_in
    |=> !phy_rx_on_out && phy_tx_on_out)
    else $error("receiver not powered down in power saving");
  a_pin_reset: assert property (@(posedge mclk_in) disable iff (reset_in)
    clk_en_in && por_d |=> chip_reset_out && power_mode_control_q == pmw_pkg::RESET_ZERO)
    else $error("power-down release did not reset registers");
  a_status_sticky: assert property (@(posedge mclk_in) disable iff (reset_in)
    interrupt_status_q[2] && !(wr && reg_addr_in == pmw_pkg::OFF_INTERRUPT_STATUS)
    && !(clk_en_in && por_d) |=> interrupt_status_q[2])
    else $error("status bit lost");
  a_linkup_bit: assert property (@(posedge mclk_in) disable iff (reset_in)
    linkup_evt |=> interrupt_status_q[3])
    else $error("link-up not flagged");
  a_remote_bit: assert property (@(posedge mclk_in) disable iff (reset_in)
    remote_evt |=> interrupt_status_q[4] ##1 (power_event_out || !$past(clk_en_in)
    || !power_mode_control_q[pmw_pkg::PMC_PME_REMOTE]))
    else $error("remote wake not reported");
  a_irq_follow: assert property (@(posedge mclk_in) disable iff (reset_in)
    clk_en_in |=> interrupt_out_n == !(|($past(interrupt_status_q) & $past(interrupt_enable_q))))
    else $error("interrupt output wrong");
  a_energy_bit: assert property (@(posedge mclk_in) disable iff (reset_in)
    energy_evt |=> interrupt_status_q[pmw_pkg::ISR_ENERGY])
    else $error("energy event not flagged");
  a_pin_off: assert property (@(posedge mclk_in) disable iff (reset_in)
    clk_en_in && !chip_power_down_pin_in |=> !clocks_on_out && !phy_tx_on_out)
    else $error("device not off while pin low");
  c_soft_cycle: cover property (@(posedge mclk_in) disable iff (reset_in)
    soft_down_q ##[1:50] !soft_down_q);
  c_remote: cover property (@(posedge mclk_in) disable iff (reset_in) remote_evt);
  c_energy: cover property (@(posedge mclk_in) disable iff (reset_in) energy_evt);
endmodule

// file: pmw_host_model.sv
/*
 pmw_host_model: host processor on the register port of the block.
 assumes one-cycle read/write strobes sampled on the rising mclk_in edge.
*/
`timescale 1ns/1ps
module pmw_host_model (
  input wire logic mclk_in,
  input wire logic [15:0] rdata_in,
  output logic rd_out,
  output logic wr_out,
  output logic [7:0] addr_out,
  output logic [15:0] wdata_out
);
  initial begin
    rd_out = 1'b0;
    wr_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 16'h0000;
  end
  // mode changes, leaving power saving and clearing interrupt status bits
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    wr_out <= 1'b1;
    addr_out <= a;
    wdata_out <= d;
    @(posedge mclk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  // a read of the reset register is also the wake command
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk_in);
    rd_out <= 1'b1;
    addr_out <= a;
    @(posedge mclk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    @(posedge mclk_in);
    #1;
    d = rdata_in;
  endtask
endmodule

// file: power_mgmt_wake_on_lan_tb.sv
/*
 power_mgmt_wake_on_lan_tb: self-checking bench for pmw_power_wake.
 assumes pmw_host_model on the register port; bench plays mac and phy.
*/
`timescale 1ns/1ps
module power_mgmt_wake_on_lan_tb;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic clk_en = 1'b1;
  logic pin = 1'b1;
  logic autoneg = 1'b0, cable = 1'b1, activity = 1'b0, energy = 1'b0, link = 1'b0;
  logic rx_start = 1'b0, rx_bv = 1'b0, rx_end = 1'b0, rx_good = 1'b0, rx_dest = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic [15:0] rx_crc = 16'h0000;
  logic [47:0] station = 48'h0a1b2c3d4e5f;
  logic rd, wr, clk_on, mac_on, tx_on, rx_on, chip_rst, int_n, pev;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, pw, irq;
  logic [7:0] fq[$];
  int failures = 0;
  int checked = 0;
  assign pw = {12'h000, clk_on, mac_on, tx_on, rx_on};
  assign irq = {14'h0000, int_n, pev};
  pmw_host_model host_i (.mclk_in(mclk_in), .rdata_in(rdata), .rd_out(rd), .wr_out(wr),
    .addr_out(addr), .wdata_out(wdata));
  pmw_power_wake #(.TICK_CYCLES(1)) pmw_power_wake_i (.mclk_in(mclk_in), .reset_in(reset_in),
    .clk_en_in(clk_en), .chip_power_down_pin_in(pin), .reg_rd_in(rd), .reg_wr_in(wr),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .station_addr_in(station),
    .autoneg_en_in(autoneg), .cable_connected_in(cable), .line_activity_in(activity),
    .energy_in(energy), .link_up_in(link), .rx_start_in(rx_start), .rx_byte_valid_in(rx_bv),
    .rx_byte_in(rx_byte), .rx_end_in(rx_end), .rx_good_in(rx_good), .rx_dest_ok_in(rx_dest),
    .rx_frame_crc_in(rx_crc), .reg_rdata_out(rdata), .clocks_on_out(clk_on),
    .mac_on_out(mac_on), .phy_tx_on_out(tx_on), .phy_rx_on_out(rx_on),
    .chip_reset_out(chip_rst), .interrupt_out_n(int_n), .power_event_out(pev));
  initial begin
    forever #50 mclk_in = ~mclk_in;
  end
  task automatic final_report();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] d;
    host_i.rd_reg(a, d);
    chk(d & m, e, $sformatf("reg %h", a));
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic wait_event();
    int n;
    n = 0;
    while (pev !== 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    if (pev !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: no power event", $time);
      final_report();
    end
  endtask
  task automatic add_seq(input int ffs, input int copies);
    repeat (ffs) fq.push_back(8'hff);
    repeat (copies) for (int k = 5; k >= 0; k--) fq.push_back(station[k*8 +: 8]);
  endtask
  task automatic send(input logic g, input logic d, input logic [15:0] c);
    @(posedge mclk_in);
    rx_start <= 1'b1;
    @(posedge mclk_in);
    rx_start <= 1'b0;
    foreach (fq[i]) begin
      rx_bv <= 1'b1;
      rx_byte <= fq[i];
      @(posedge mclk_in);
    end
    rx_bv <= 1'b0;
    rx_byte <= ~rx_byte;
    rx_end <= 1'b1;
    rx_good <= g;
    rx_dest <= d;
    rx_crc <= c;
    @(posedge mclk_in);
    rx_end <= 1'b0;
    rx_crc <= ~c;
    fq.delete();
    tick(3);
  endtask
  task automatic test_reset();
    chk(pw, 16'h000f, "power outs");
    chk(irq, 16'h0002, "irq outs");
    rchk(pmw_pkg::OFF_POWER_MODE_CONTROL, 16'h0003, 16'h0000);
    rchk(pmw_pkg::OFF_WAKE_UP_TIME, 16'hffff, pmw_pkg::WAKE_TIME_RESET);
    rchk(8'h3c, 16'hffff, 16'h0000);
    $display("reset test done");
  endtask
  task automatic test_soft_down();
    logic [15:0] d;
    host_i.wr_reg(pmw_pkg::OFF_WAKE_UP_TIME, 16'h0020);
    host_i.wr_reg(pmw_pkg::OFF_POWER_MODE_CONTROL, 16'h0002);
    tick(2);
    chk(pw, 16'h0000, "soft down outs");
    host_i.wr_reg(pmw_pkg::OFF_WAKE_UP_TIME, 16'h0055);
    host_i.rd_reg(pmw_pkg::OFF_WAKE_UP_TIME, d);
    chk(pw, 16'h0000, "still down");
    host_i.rd_reg(pmw_pkg::OFF_GLOBAL_RESET_WAKE, d);
    tick(2);
    chk(pw, 16'h000f, "woken outs");
    rchk(pmw_pkg::OFF_WAKE_UP_TIME, 16'hffff, 16'h0020);
    $display("soft down test done");
  endtask
  task automatic test_saving();
    @(posedge mclk_in);
    autoneg <= 1'b1;
    cable <= 1'b0;
    host_i.wr_reg(pmw_pkg::OFF_PHY_SPECIAL_CONTROL, 16'h0400);
    host_i.wr_reg(pmw_pkg::OFF_POWER_MODE_CONTROL, 16'h0003);
    tick(2);
    chk(pw, 16'h000e, "saving outs");
    rchk(pmw_pkg::OFF_PHY_SPECIAL_CONTROL, 16'hffff, 16'h0400);
    @(posedge mclk_in);
    activity <= 1'b1;
    tick(2);
    chk(pw, 16'h000f, "activity wakes rx");
    activity <= 1'b0;
    cable <= 1'b1;
    tick(2);
    chk(pw, 16'h000f, "cable blocks");
    cable <= 1'b0;
    autoneg <= 1'b0;
    tick(2);
    chk(pw, 16'h000f, "autoneg blocks");
    autoneg <= 1'b1;
    host_i.wr_reg(pmw_pkg::OFF_PHY_SPECIAL_CONTROL, 16'h0000);
    host_i.wr_reg(pmw_pkg::OFF_POWER_MODE_CONTROL, 16'h0000);
    tick(2);
    chk(pw, 16'h000f, "left saving");
    $display("saving test done");
  endtask
  task automatic test_energy_link();
    host_i.wr_reg(pmw_pkg::OFF_WAKE_UP_TIME, 16'h0004);
    host_i.wr_reg(pmw_pkg::OFF_INTERRUPT_ENABLE, 16'h0004);
    host_i.wr_reg(pmw_pkg::OFF_POWER_MODE_CONTROL, 16'h0100);
    @(posedge mclk_in);
    energy <= 1'b1;
    repeat (3) @(posedge mclk_in);
    energy <= 1'b0;
    rchk(pmw_pkg::OFF_INTERRUPT_STATUS, 16'h0004, 16'h0000);
    @(posedge mclk_in);
    energy <= 1'b1;
    repeat (12) @(posedge mclk_in);
    energy <= 1'b0;
    wait_event();
    rchk(pmw_pkg::OFF_INTERRUPT_STATUS, 16'h0004, 16'h0004);
    chk(irq, 16'h0001, "energy irq");
    host_i.wr_reg(pmw_pkg::OFF_INTERRUPT_STATUS, 16'h0004);
    host_i.wr_reg(pmw_pkg::OFF_INTERRUPT_ENABLE, 16'h0000);
    host_i.wr_reg(pmw_pkg::OFF_POWER_MODE_CONTROL, 16'h0000);
    link <= 1'b1;
    tick(3);
    rchk(pmw_pkg::OFF_INTERRUPT_STATUS, 16'h003c, 16'h0008);
    chk(irq, 16'h0002, "masked link");
    host_i.wr_reg(pmw_pkg::OFF_INTERRUPT_ENABLE, 16'h0008);
    tick(2);
    chk(irq, 16'h0000, "link irq");
    host_i.wr_reg(pmw_pkg::OFF_INTERRUPT_STATUS, 16'hffff);
    tick(2);
    chk(irq, 16'h0002, "cleared");
    $display("energy and link test done");
  endtask
  task automatic test_remote();
    host_i.wr_reg(pmw_pkg::OFF_WAKE_FRAME_CONTROL, 16'h0080);
    host_i.wr_reg(pmw_pkg::OFF_POWER_MODE_CONTROL, 16'h0400);
    add_seq(6, 1);
    add_seq(6, 3);
    fq.push_back(8'h00);
    add_seq(7, 16);
    send(1'b1, 1'b1, 16'h0000);
    wait_event();
    rchk(pmw_pkg::OFF_INTERRUPT_STATUS, 16'h0010, 16'h0010);
    host_i.wr_reg(pmw_pkg::OFF_INTERRUPT_STATUS, 16'h0010);
    add_seq(6, 15);
    send(1'b1, 1'b1, 16'h0000);
    rchk(pmw_pkg::OFF_INTERRUPT_STATUS, 16'h0010, 16'h0000);
    add_seq(6, 16);
    send(1'b0, 1'b1, 16'h0000);
    rchk(pmw_pkg::OFF_INTERRUPT_STATUS, 16'h0010, 16'h0000);
    add_seq(6, 16);
    send(1'b1, 1'b0, 16'h0000);
    rchk(pmw_pkg::OFF_INTERRUPT_STATUS, 16'h0010, 16'h0000);
    host_i.wr_reg(pmw_pkg::OFF_WAKE_FRAME_CONTROL, 16'h0000);
    add_seq(6, 16);
    send(1'b1, 1'b1, 16'h0000);
    rchk(pmw_pkg::OFF_INTERRUPT_STATUS, 16'h0010, 16'h0000);
    chk(irq, 16'h0002, "no event");
    $display("remote wake test done");
  endtask
  task automatic test_frames();
    host_i.wr_reg(pmw_pkg::OFF_POWER_MODE_CONTROL, 16'h0800);
    for (int i = 0; i < 4; i++) begin
      host_i.wr_reg(pmw_pkg::OFF_WAKE_FRAME0 + 8'(16 * i), 16'ha5a0 + 16'(i));
      host_i.wr_reg(pmw_pkg::OFF_WAKE_FRAME_CONTROL, 16'h0001 << ((i + 1) % 4));
      send(1'b1, 1'b1, 16'ha5a0 + 16'(i));
      rchk(pmw_pkg::OFF_INTERRUPT_STATUS, 16'h0020, 16'h0000);
      host_i.wr_reg(pmw_pkg::OFF_WAKE_FRAME_CONTROL, 16'h0001 << i);
      send(1'b1, 1'b1, 16'ha5a0 + 16'(i));
      rchk(pmw_pkg::OFF_INTERRUPT_STATUS, 16'h0020, 16'h0020);
      chk({15'h0000, pev}, 16'h0001, "frame event");
      host_i.wr_reg(pmw_pkg::OFF_INTERRUPT_STATUS, 16'h0020);
    end
    $display("wake frame test done");
  endtask
  task automatic test_pin();
    logic seen;
    seen = 1'b0;
    host_i.wr_reg(pmw_pkg::OFF_WAKE_UP_TIME, 16'h0033);
    clk_en <= 1'b0;
    host_i.wr_reg(pmw_pkg::OFF_WAKE_UP_TIME, 16'h0044);
    clk_en <= 1'b1;
    rchk(pmw_pkg::OFF_WAKE_UP_TIME, 16'hffff, 16'h0033);
    @(posedge mclk_in);
    pin <= 1'b0;
    repeat (3) @(posedge mclk_in);
    tick(1);
    chk(pw, 16'h0000, "pin low outs");
    pin <= 1'b1;
    repeat (6) begin
      tick(1);
      if (chip_rst === 1'b1) seen = 1'b1;
    end
    chk({15'h0000, seen}, 16'h0001, "chip reset pulse");
    rchk(pmw_pkg::OFF_WAKE_UP_TIME, 16'hffff, pmw_pkg::WAKE_TIME_RESET);
    rchk(pmw_pkg::OFF_WAKE_FRAME_CONTROL, 16'hffff, 16'h0000);
    $display("power-down pin test done");
  endtask
  initial begin
    repeat (16) @(posedge mclk_in);
    reset_in <= 1'b0;
    tick(1);
    test_reset();
    test_soft_down();
    test_saving();
    test_energy_link();
    test_remote();
    test_frames();
    test_pin();
    final_report();
  end
  initial begin
    #9ms;
    failures++;
    $display("unexpected at %0t: run too long", $time);
    final_report();
  end
endmodule
